// ==== src/tapdec_defines.svh ====
`ifndef TAPDEC_DEFINES_SVH
`define TAPDEC_DEFINES_SVH
// instruction register geometry and codes
`define TAPDEC_IR_W 4
`define TAPDEC_IR_RESET 4'h2
`define TAPDEC_IR_CAPT_LOW 2'h1
`define TAPDEC_STAT_NORMAL 2'h0
`define TAPDEC_STAT_DEBUG 2'h3
`define TAPDEC_OP_EXTEST 4'h0
`define TAPDEC_OP_SAMPLE 4'h1
`define TAPDEC_OP_IDCODE 4'h2
`define TAPDEC_OP_EXTPULL 4'h3
`define TAPDEC_OP_HIGHZ 4'h4
`define TAPDEC_OP_CLAMP 4'h5
`define TAPDEC_OP_DBGCONN 4'h6
`define TAPDEC_OP_HALTREQ 4'h7
`define TAPDEC_OP_BYPASS 4'hF
// identification register
`define TAPDEC_ID_W 32
`define TAPDEC_ID_DEFAULT 32'h00000001
`endif

// ==== src/tapdec_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// synchronised pin view shared between the top and the edge finder
interface tapdec_link_if;
   logic tck_rise;
   logic tck_fall;
   logic tms_s;
   logic tdi_s;
   modport sync (output tck_rise, output tck_fall, output tms_s, output tdi_s);
   modport core (input tck_rise, input tck_fall, input tms_s, input tdi_s);
endinterface
`default_nettype wire

// ==== src/tapdec_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// two-flop synchronisers for the test pins plus tck edge detection
module tapdec_pin_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tck_pin,
   input wire logic tms_pin,
   input wire logic tdi_pin,
   tapdec_link_if.sync lnk
);
   logic [2:0] meta_reg; // first stage, read only by second stage
   logic [2:0] sync_reg; // second stage {tck,tms,tdi}
   logic tck_last_reg; // previous synced tck for edge finding
   // synchroniser chain
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_reg <= 3'h0;
         sync_reg <= 3'h0;
         tck_last_reg <= 1'b0;
      end else begin
         meta_reg <= {tck_pin, tms_pin, tdi_pin};
         sync_reg <= meta_reg;
         tck_last_reg <= sync_reg[2];
      end
   end
   // edges derive from stable second-stage values only
   assign lnk.tck_rise = sync_reg[2] & ~tck_last_reg;
   assign lnk.tck_fall = ~sync_reg[2] & tck_last_reg;
   assign lnk.tms_s = sync_reg[1];
   assign lnk.tdi_s = sync_reg[0];
endmodule // tapdec_pin_sync
`default_nettype wire

// ==== src/tapdec_pkg.sv ====
package tapdec_pkg;
   // tap controller states, gray-ish coding along the dr and ir paths
   typedef enum logic [3:0] {
      TAPDEC_RESET = 4'h0,
      TAPDEC_IDLE = 4'h1,
      TAPDEC_SEL_DR = 4'h3,
      TAPDEC_CAP_DR = 4'h2,
      TAPDEC_SH_DR = 4'h6,
      TAPDEC_EX1_DR = 4'h7,
      TAPDEC_PAU_DR = 4'h5,
      TAPDEC_EX2_DR = 4'h4,
      TAPDEC_UPD_DR = 4'hC,
      TAPDEC_SEL_IR = 4'hD,
      TAPDEC_CAP_IR = 4'hF,
      TAPDEC_SH_IR = 4'hE,
      TAPDEC_EX1_IR = 4'hA,
      TAPDEC_PAU_IR = 4'hB,
      TAPDEC_EX2_IR = 4'h9,
      TAPDEC_UPD_IR = 4'h8
   } tapdec_state_t;
endpackage

// ==== src/tapdec_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tapdec_defines.svh"
module tapdec_top #(
   parameter int BSC_LEN = 8, // boundary cells count
   parameter logic [31:0] ID_VALUE = `TAPDEC_ID_DEFAULT // arbitrary identity value
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   input wire logic TRST_N,
   output logic TDO,
   output logic TDO_OE_N,
   input wire logic DEBUG_MODE,
   input wire logic DEBUG_TRIGGER,
   output logic DEBUG_EVENT_OUT_N,
   input wire logic DBG_TDO,
   output logic DBG_TDI,
   output logic DBG_SHIFT,
   output logic DBG_CAPTURE,
   output logic DBG_UPDATE,
   output logic DBG_SELECTED,
   output logic HALT_REQUEST,
   output logic SYS_RESET_HOLD,
   output logic EXT_WEAK_PULLUP,
   output logic PINS_HIGHZ,
   output logic BSC_OVERRIDE,
   input wire logic [BSC_LEN-1:0] BSC_PIN_IN,
   output logic [BSC_LEN-1:0] BSC_PIN_OUT
);
   // shift and capture slices need at least two cells
   if (BSC_LEN < 2) begin : g_bsc_len_check
      $error("boundary chain too short");
   end

   tapdec_link_if lnk ();
   logic trst_meta_reg; // trst first stage
   logic trst_n_reg; // synchronised trst
   tapdec_pkg::tapdec_state_t state_reg; // controller state
   tapdec_pkg::tapdec_state_t state_next; // next controller state
   logic [`TAPDEC_IR_W-1:0] ir_shift_reg; // instruction shift stage
   logic [`TAPDEC_IR_W-1:0] test_instruction_reg; // active instruction
   logic [`TAPDEC_ID_W-1:0] chip_ident_reg; // identification shift stage
   logic [BSC_LEN-1:0] boundary_cell_chain; // boundary shift stage
   logic [BSC_LEN-1:0] bsc_update_reg; // boundary output latches
   logic single_bit_path_reg; // bypass bit
   logic tdo_reg; // tdo flop, changes on tck fall
   logic tdo_oe_n_reg;
   logic dbg_reg; // debug event output flop
   logic [1:0] output_status_bits; // captured status pair
   logic sel_bsc;
   logic sel_id;
   logic sel_dbg;
   logic serial_bit;

   // pin synchroniser and tck edge finder
   tapdec_pin_sync u_sync (
      .clk(CORE_CLK),
      .rst_n(RSTN),
      .tck_pin(TCK),
      .tms_pin(TMS),
      .tdi_pin(TDI),
      .lnk(lnk)
   );

   // test reset synchroniser, separate from system reset path
   always_ff @(posedge CORE_CLK) begin
      trst_meta_reg <= TRST_N;
      trst_n_reg <= trst_meta_reg;
   end

   // decoded register selection
   function automatic logic is_bsc_op(input logic [`TAPDEC_IR_W-1:0] op);
      return (op == `TAPDEC_OP_EXTEST) || (op == `TAPDEC_OP_SAMPLE) ||
         (op == `TAPDEC_OP_EXTPULL);
   endfunction

   // serial status follows debug mode
   assign output_status_bits = DEBUG_MODE ? `TAPDEC_STAT_DEBUG : `TAPDEC_STAT_NORMAL;
   assign sel_bsc = is_bsc_op(test_instruction_reg);
   assign sel_id = (test_instruction_reg == `TAPDEC_IR_RESET);
   assign sel_dbg = (test_instruction_reg == `TAPDEC_OP_DBGCONN);

   // next state on tms, standard sixteen-state walk
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         tapdec_pkg::TAPDEC_RESET: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_RESET : tapdec_pkg::TAPDEC_IDLE;
         end
         tapdec_pkg::TAPDEC_IDLE: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_SEL_DR : tapdec_pkg::TAPDEC_IDLE;
         end
         tapdec_pkg::TAPDEC_SEL_DR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_SEL_IR : tapdec_pkg::TAPDEC_CAP_DR;
         end
         tapdec_pkg::TAPDEC_CAP_DR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_EX1_DR : tapdec_pkg::TAPDEC_SH_DR;
         end
         tapdec_pkg::TAPDEC_SH_DR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_EX1_DR : tapdec_pkg::TAPDEC_SH_DR;
         end
         tapdec_pkg::TAPDEC_EX1_DR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_UPD_DR : tapdec_pkg::TAPDEC_PAU_DR;
         end
         tapdec_pkg::TAPDEC_PAU_DR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_EX2_DR : tapdec_pkg::TAPDEC_PAU_DR;
         end
         tapdec_pkg::TAPDEC_EX2_DR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_UPD_DR : tapdec_pkg::TAPDEC_SH_DR;
         end
         tapdec_pkg::TAPDEC_UPD_DR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_SEL_DR : tapdec_pkg::TAPDEC_IDLE;
         end
         tapdec_pkg::TAPDEC_SEL_IR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_RESET : tapdec_pkg::TAPDEC_CAP_IR;
         end
         tapdec_pkg::TAPDEC_CAP_IR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_EX1_IR : tapdec_pkg::TAPDEC_SH_IR;
         end
         tapdec_pkg::TAPDEC_SH_IR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_EX1_IR : tapdec_pkg::TAPDEC_SH_IR;
         end
         tapdec_pkg::TAPDEC_EX1_IR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_UPD_IR : tapdec_pkg::TAPDEC_PAU_IR;
         end
         tapdec_pkg::TAPDEC_PAU_IR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_EX2_IR : tapdec_pkg::TAPDEC_PAU_IR;
         end
         tapdec_pkg::TAPDEC_EX2_IR: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_UPD_IR : tapdec_pkg::TAPDEC_SH_IR;
         end
         default: begin
            state_next = lnk.tms_s ? tapdec_pkg::TAPDEC_SEL_DR : tapdec_pkg::TAPDEC_IDLE;
         end
      endcase
   end

   // controller advances on tck rise; test reset overrides, system reset too
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN || !trst_n_reg) begin
         state_reg <= tapdec_pkg::TAPDEC_RESET;
      end else if (lnk.tck_rise) begin
         state_reg <= state_next;
      end
   end

   // instruction shift stage: capture, shift
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN || !trst_n_reg) begin
         ir_shift_reg <= `TAPDEC_IR_RESET;
      end else if (lnk.tck_rise) begin
         if (state_reg == tapdec_pkg::TAPDEC_CAP_IR) begin
            // status in upper pair, fixed 01 below
            ir_shift_reg <= {output_status_bits, `TAPDEC_IR_CAPT_LOW};
         end else if (state_reg == tapdec_pkg::TAPDEC_SH_IR) begin
            ir_shift_reg <= {lnk.tdi_s, ir_shift_reg[`TAPDEC_IR_W-1:1]};
         end
      end
   end

   // active instruction: reset loads idcode, updated on update-ir fall
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN || !trst_n_reg) begin
         test_instruction_reg <= `TAPDEC_IR_RESET;
      end else if (state_reg == tapdec_pkg::TAPDEC_RESET) begin
         test_instruction_reg <= `TAPDEC_IR_RESET;
      end else if (lnk.tck_fall && state_reg == tapdec_pkg::TAPDEC_UPD_IR) begin
         // reserved codes are loaded as-is; probe must avoid them
         test_instruction_reg <= ir_shift_reg;
      end
   end

   // identification register: capture value, shift through
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         chip_ident_reg <= `TAPDEC_ID_DEFAULT;
      end else if (lnk.tck_rise && sel_id) begin
         if (state_reg == tapdec_pkg::TAPDEC_CAP_DR) begin
            chip_ident_reg <= {ID_VALUE[`TAPDEC_ID_W-1:1], 1'b1};
         end else if (state_reg == tapdec_pkg::TAPDEC_SH_DR) begin
            chip_ident_reg <= {lnk.tdi_s, chip_ident_reg[`TAPDEC_ID_W-1:1]};
         end
      end
   end

   // boundary chain: captures pin levels, shifts under its instructions
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         boundary_cell_chain <= '0;
      end else if (lnk.tck_rise && sel_bsc) begin
         if (state_reg == tapdec_pkg::TAPDEC_CAP_DR) begin
            boundary_cell_chain <= BSC_PIN_IN;
         end else if (state_reg == tapdec_pkg::TAPDEC_SH_DR) begin
            boundary_cell_chain <= {lnk.tdi_s, boundary_cell_chain[BSC_LEN-1:1]};
         end
      end
   end

   // boundary output latches update on update-dr fall, kept through clamp
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN || !trst_n_reg) begin
         bsc_update_reg <= '0;
      end else if (lnk.tck_fall && sel_bsc && state_reg == tapdec_pkg::TAPDEC_UPD_DR) begin
         bsc_update_reg <= boundary_cell_chain;
      end
   end

   // bypass bit for every instruction without its own data register
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         single_bit_path_reg <= 1'b0;
      end else if (lnk.tck_rise) begin
         if (state_reg == tapdec_pkg::TAPDEC_CAP_DR) begin
            single_bit_path_reg <= 1'b0;
         end else if (state_reg == tapdec_pkg::TAPDEC_SH_DR) begin
            single_bit_path_reg <= lnk.tdi_s;
         end
      end
   end

   // serial output select
   always_comb begin
      if (state_reg == tapdec_pkg::TAPDEC_SH_IR) begin
         serial_bit = ir_shift_reg[0];
      end else if (sel_bsc) begin
         serial_bit = boundary_cell_chain[0];
      end else if (sel_id) begin
         serial_bit = chip_ident_reg[0];
      end else if (sel_dbg) begin
         serial_bit = DBG_TDO;
      end else begin
         serial_bit = single_bit_path_reg;
      end
   end

   // tdo changes on tck fall; enable only in shift states
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN || !trst_n_reg) begin
         tdo_reg <= 1'b0;
         tdo_oe_n_reg <= 1'b1;
      end else if (lnk.tck_fall) begin
         tdo_reg <= serial_bit;
         tdo_oe_n_reg <= !(state_reg == tapdec_pkg::TAPDEC_SH_IR ||
            state_reg == tapdec_pkg::TAPDEC_SH_DR);
      end
   end

   // debug event flop, active low
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         dbg_reg <= 1'b1;
      end else begin
         dbg_reg <= ~DEBUG_TRIGGER;
      end
   end

   assign TDO = tdo_reg;
   assign TDO_OE_N = tdo_oe_n_reg;
   assign DEBUG_EVENT_OUT_N = dbg_reg;
   // debug module shares the one controller; shift and capture strobes are tck-rise pulses, update a tck-fall pulse
   assign DBG_TDI = lnk.tdi_s;
   assign DBG_SELECTED = sel_dbg;
   assign DBG_SHIFT = sel_dbg && lnk.tck_rise && state_reg == tapdec_pkg::TAPDEC_SH_DR;
   assign DBG_CAPTURE = sel_dbg && lnk.tck_rise && state_reg == tapdec_pkg::TAPDEC_CAP_DR;
   assign DBG_UPDATE = sel_dbg && lnk.tck_fall && state_reg == tapdec_pkg::TAPDEC_UPD_DR;
   assign HALT_REQUEST = (test_instruction_reg == `TAPDEC_OP_HALTREQ);
   // system logic held in reset under pin-owning instructions
   assign SYS_RESET_HOLD = (test_instruction_reg == `TAPDEC_OP_EXTEST) ||
      (test_instruction_reg == `TAPDEC_OP_EXTPULL) ||
      (test_instruction_reg == `TAPDEC_OP_HIGHZ) ||
      (test_instruction_reg == `TAPDEC_OP_CLAMP);
   assign EXT_WEAK_PULLUP = (test_instruction_reg == `TAPDEC_OP_EXTPULL);
   assign PINS_HIGHZ = (test_instruction_reg == `TAPDEC_OP_HIGHZ);
   assign BSC_OVERRIDE = (test_instruction_reg == `TAPDEC_OP_EXTEST) ||
      (test_instruction_reg == `TAPDEC_OP_EXTPULL) ||
      (test_instruction_reg == `TAPDEC_OP_CLAMP);
   assign BSC_PIN_OUT = bsc_update_reg;
endmodule // tapdec_top
`default_nettype wire

// ==== tb/tapdec_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the test port front end
module tapdec_checker #(
   parameter int BSC_LEN = 8 // boundary cells count
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic TCK,
   input wire logic TDI,
   input wire logic TRST_N,
   input wire logic TDO,
   input wire logic TDO_OE_N,
   input wire logic DEBUG_TRIGGER,
   input wire logic DEBUG_EVENT_OUT_N,
   input wire logic DBG_TDI,
   input wire logic DBG_SHIFT,
   input wire logic DBG_UPDATE,
   input wire logic DBG_SELECTED,
   input wire logic HALT_REQUEST,
   input wire logic SYS_RESET_HOLD,
   input wire logic EXT_WEAK_PULLUP,
   input wire logic PINS_HIGHZ,
   input wire logic BSC_OVERRIDE,
   input wire logic [BSC_LEN-1:0] BSC_PIN_OUT
);
   logic [2:0] up_cnt_reg; // cycles since reset, saturating
   // synchronisers refill after reset, so timing checks wait for this count
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) up_cnt_reg <= 3'h0;
      else if (up_cnt_reg != 3'h7) up_cnt_reg <= up_cnt_reg + 3'h1;
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   // input level held long enough to cross two flops
   sequence s_tdi_steady; $stable(TDI)[*3]; endsequence
   // strobe lasts a single core clock on the chosen debug path
   sequence s_one_shot; DBG_SELECTED && $past(TCK, 2) ##1 !DBG_SHIFT; endsequence
   AST_TDI_FANOUT: assert property (s_tdi_steady ##0 (up_cnt_reg == 3'h7) |-> DBG_TDI == TDI)
      else $error("debug data input does not follow the serial input");
   AST_OUT_ON_FALL: assert property ((up_cnt_reg == 3'h7) && ($changed(TDO) ||
      $changed(TDO_OE_N) || $changed(BSC_PIN_OUT)) |-> !$past(TCK, 2))
      else $error("serial output or pin latch moved outside the low clock phase");
   AST_SHIFT_PULSE: assert property (DBG_SHIFT |-> s_one_shot)
      else $error("debug shift strobe malformed");
   AST_UPDATE_FALL: assert property ($rose(DBG_UPDATE) |-> DBG_SELECTED &&
      !$past(TCK, 2) ##1 $fell(DBG_UPDATE))
      else $error("debug update strobe malformed");
   AST_EVENT_OUT: assert property ((up_cnt_reg != 3'h0) |->
      DEBUG_EVENT_OUT_N == !$past(DEBUG_TRIGGER))
      else $error("debug event output does not show the trigger");
   AST_EXT_HOLD: assert property (BSC_OVERRIDE || PINS_HIGHZ |->
      SYS_RESET_HOLD && !(BSC_OVERRIDE && PINS_HIGHZ))
      else $error("pin control mode without system hold");
   AST_PULLUP: assert property (EXT_WEAK_PULLUP |-> BSC_OVERRIDE && !HALT_REQUEST)
      else $error("weak pull-up outside its external test mode");
   AST_EXCLUSIVE: assert property (DBG_SELECTED || HALT_REQUEST |-> !SYS_RESET_HOLD &&
      !BSC_OVERRIDE && !(DBG_SELECTED && HALT_REQUEST))
      else $error("debug instructions decoded together with others");
   AST_RESET_ID: assert property ($rose(RSTN) |-> TDO_OE_N && !DBG_SELECTED &&
      !SYS_RESET_HOLD && !HALT_REQUEST)
      else $error("reset did not leave the identity instruction");
   AST_TEST_RESET: assert property (!TRST_N [*4] |=> TDO_OE_N && !DBG_SELECTED &&
      !SYS_RESET_HOLD)
      else $error("test reset did not clear the port");
endmodule // tapdec_checker
bind tapdec_top tapdec_checker #(.BSC_LEN(BSC_LEN)) chk_u (
   .CORE_CLK(CORE_CLK), .RSTN(RSTN), .TCK(TCK), .TDI(TDI), .TRST_N(TRST_N), .TDO(TDO),
   .TDO_OE_N(TDO_OE_N), .DEBUG_TRIGGER(DEBUG_TRIGGER), .DEBUG_EVENT_OUT_N(DEBUG_EVENT_OUT_N),
   .DBG_TDI(DBG_TDI), .DBG_SHIFT(DBG_SHIFT), .DBG_UPDATE(DBG_UPDATE),
   .DBG_SELECTED(DBG_SELECTED), .HALT_REQUEST(HALT_REQUEST), .SYS_RESET_HOLD(SYS_RESET_HOLD),
   .EXT_WEAK_PULLUP(EXT_WEAK_PULLUP), .PINS_HIGHZ(PINS_HIGHZ), .BSC_OVERRIDE(BSC_OVERRIDE),
   .BSC_PIN_OUT(BSC_PIN_OUT));
`default_nettype wire

// ==== tb/tapdec_probe.sv ====
`timescale 1ns/1ps
`default_nettype none
// behavioural test probe; clock stands low between calls
module tapdec_probe (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   logic oe_ok; // every shifted bit was driven
   // idle pins rest at their pull levels
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // one test clock: pins set in the low phase, output sampled late in the high phase
   task automatic tick(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #200 tck = 1'b1;
      #190 q = tdo;
      #10 tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   endtask
   // five high mode bits reach reset from any state, then idle
   task automatic to_idle();
      logic q;
      repeat (5) tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
   endtask
   // whole scan from idle back to idle, n bits lsb first
   task automatic scan(input logic ir, input int n, input logic [39:0] din,
      output logic [39:0] dout);
      logic q;
      dout = 40'h0;
      oe_ok = 1'b1;
      tick(1'b1, 1'b1, q);
      if (ir) tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
      tick(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
         oe_ok &= !tdo_oe_n;
      end
      tick(1'b1, 1'b1, q); // update lands on this falling edge
      tick(1'b0, 1'b1, q);
   endtask
endmodule // tapdec_probe
`default_nettype wire

// ==== tb/tapdec_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// self-checking bench driving the test port through the probe model
module tapdec_tb_top;
   localparam int BSC_N = 8; // short boundary chain
   localparam logic [31:0] TB_ID = 32'h5A3C0F01; // arbitrary identity value, lsb one
   localparam logic [39:0] PAT = 40'hC396E17B2D; // shift pattern
   localparam logic [BSC_N-1:0] PINS = 8'hA5; // levels on the boundary inputs
   logic clk, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe_n, mode, trig, evt_n, dtdo, dtdi;
   logic dsh, dcap, dupd, dsel, halt, hold, pull, hiz, ovr, q;
   logic [BSC_N-1:0] pin_out; // update latches
   logic [39:0] dout, exp; // scan result and expectation
   logic [7:0] n_sh, n_cap, n_upd; // debug strobes seen in a scan
   logic [3:0] code; // instruction under test
   logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
   int error_cnt = 0;
   int samples_checked = 0;
   tapdec_top #(.BSC_LEN(BSC_N), .ID_VALUE(TB_ID)) dut_u (
      .CORE_CLK(clk), .RSTN(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n),
      .TDO(tdo), .TDO_OE_N(tdo_oe_n), .DEBUG_MODE(mode), .DEBUG_TRIGGER(trig),
      .DEBUG_EVENT_OUT_N(evt_n), .DBG_TDO(dtdo), .DBG_TDI(dtdi), .DBG_SHIFT(dsh),
      .DBG_CAPTURE(dcap), .DBG_UPDATE(dupd), .DBG_SELECTED(dsel), .HALT_REQUEST(halt),
      .SYS_RESET_HOLD(hold), .EXT_WEAK_PULLUP(pull), .PINS_HIGHZ(hiz), .BSC_OVERRIDE(ovr),
      .BSC_PIN_IN(PINS), .BSC_PIN_OUT(pin_out));
   tapdec_probe probe_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
   // core clock, 50 ns
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // debug strobes are one core clock wide, so count per edge
   always @(posedge clk) begin
      if (dsh === 1'b1) n_sh <= n_sh + 8'h01;
      if (dcap === 1'b1) n_cap <= n_cap + 8'h01;
      if (dupd === 1'b1) n_upd <= n_upd + 8'h01;
   end
   // compare and report
   task automatic check(input string what, input logic [39:0] e, input logic [39:0] got);
      samples_checked++;
      if (got !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, e, got);
      end
   endtask
   // verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // run is about 240 us; a hang stops well after that
   initial begin
      #1000000;
      error_cnt++;
      $display("MISMATCH watchdog expected done seen timeout");
      results();
   end
   // main sequence
   initial begin
      {rst_n, trst_n, mode, trig, dtdo} = 5'h09;
      {n_sh, n_cap, n_upd} = 24'h0;
      repeat (12) @(posedge clk);
      #5 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      probe_u.to_idle();
      probe_u.scan(1'b0, 8'h28, PAT, dout);
      check("id after reset", {PAT[7:0], TB_ID}, dout);
      foreach (codes[k]) begin
         code = codes[k];
         @(posedge clk) #5 mode = code[0];
         probe_u.scan(1'b1, 4, {36'h0, code}, dout);
         check("ir capture", {36'h0, {2{code[0]}}, 2'h1}, dout);
         check("shift drive", {39'h0, probe_u.oe_ok}, 40'h1);
         exp = {34'h0, code == 4'h6, code == 4'h7, code inside {4'h0, 4'h3, 4'h4, 4'h5},
            code == 4'h3, code == 4'h4, code inside {4'h0, 4'h3, 4'h5}};
         check("decode", exp, {34'h0, dsel, halt, hold, pull, hiz, ovr});
         {n_sh, n_cap, n_upd} = 24'h0;
         probe_u.scan(1'b0, 8'h28, PAT, dout);
         case (code)
            4'h0, 4'h1, 4'h3: exp = {PAT[31:0], PINS};
            4'h6: exp = {40{1'b1}};
            default: exp = {PAT[38:0], 1'b0};
         endcase
         check("data path", exp, dout);
         exp = (code == 4'h6) ? 40'h0000280101 : 40'h0;
         check("debug strobes", exp, {16'h0, n_sh, n_cap, n_upd});
         if (code inside {4'h0, 4'h1, 4'h3})
            check("pin latch", {32'h0, PAT[39:32]}, {32'h0, pin_out});
      end
      @(posedge clk) #5 trig = 1'b1;
      @(posedge clk) #5 check("event low", 40'h0, {39'h0, evt_n});
      trig = 1'b0;
      @(posedge clk) #5 check("event high", 40'h1, {39'h0, evt_n});
      trst_n = 1'b0;
      repeat (4) @(posedge clk);
      #5 trst_n = 1'b1;
      repeat (3) @(posedge clk);
      probe_u.tick(1'b0, 1'b1, q);
      probe_u.scan(1'b0, 8'h28, PAT, dout);
      check("id after test reset", {PAT[7:0], TB_ID}, dout);
      probe_u.scan(1'b1, 4, 40'hF, dout);
      probe_u.to_idle();
      probe_u.scan(1'b0, 8'h28, PAT, dout);
      check("id after mode reset", {PAT[7:0], TB_ID}, dout);
      results();
   end
endmodule // tapdec_tb_top
`default_nettype wire
